// ---- pkg/debug_monitor_pkg.sv ----
// Purpose: Shared constants and types for the bus debug monitor.
// Assumes: Registers are word aligned; byte address is four times the index.
// Notes: Indices above the range control register are placed next to it.
package debug_monitor_pkg;

  // Bus and register geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // Register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_MAIN_CONTROL = 10'h100;
  localparam logic [IDX_W-1:0] IDX_RANGE_CONTROL = 10'h101;
  localparam logic [IDX_W-1:0] IDX_CMP_A_CONTROL = 10'h102;
  localparam logic [IDX_W-1:0] IDX_CMP_B_CONTROL = 10'h103;
  localparam logic [IDX_W-1:0] IDX_CMP_C_CONTROL = 10'h104;
  localparam logic [IDX_W-1:0] IDX_CMP_D_CONTROL = 10'h105;
  localparam logic [IDX_W-1:0] IDX_CMP_A_ADDR = 10'h106;
  localparam logic [IDX_W-1:0] IDX_CMP_B_ADDR = 10'h107;
  localparam logic [IDX_W-1:0] IDX_CMP_C_ADDR = 10'h108;
  localparam logic [IDX_W-1:0] IDX_CMP_D_ADDR = 10'h109;
  localparam logic [IDX_W-1:0] IDX_DATA_A = 10'h10A;
  localparam logic [IDX_W-1:0] IDX_MASK_A = 10'h10B;
  localparam logic [IDX_W-1:0] IDX_INVERT_A = 10'h10C;
  localparam logic [IDX_W-1:0] IDX_SEQ_FIRST = 10'h10D;
  localparam logic [IDX_W-1:0] IDX_SEQ_SECOND = 10'h10E;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h10F;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h110;
  localparam logic [IDX_W-1:0] IDX_STATE = 10'h111;

  // Main control fields
  localparam int MAIN_ARM_BIT = 7;
  localparam int MAIN_FORCE_FINAL_STATE_BIT_BIT = 6;
  localparam int MAIN_ROUTE_BIT = 4;
  localparam int MAIN_CPUBRK_BIT = 3;
  localparam int MAIN_EXT_BIT = 1;
  localparam logic [7:0] MAIN_STORE_MASK = 8'h1A;
  localparam logic [7:0] MAIN_CONTROL_RST = 8'h00;

  // Comparator control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OPC_BIT = 1;
  localparam int CTRL_DIRQ_BIT = 2;
  localparam int CTRL_READ_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Range modes
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [1:0] RANGE_INSIDE = 2'h1;
  localparam logic [1:0] RANGE_OUTSIDE = 2'h2;

  // Status layout: one bit per channel, then trigger and session end
  localparam int STATUS_W = 6;
  localparam int ST_FORCE_FINAL_STATE_BIT_BIT = 4;
  localparam int ST_DONE_BIT = 5;

  // Sequencer targets, two bits per channel
  localparam logic [1:0] TGT_STAY = 2'h0;
  localparam logic [1:0] TGT_FIRST = 2'h1;
  localparam logic [1:0] TGT_SECOND = 2'h2;
  localparam logic [1:0] TGT_FINAL = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FIRST = 4'h2,
    ST_SECOND = 4'h4,
    ST_FINAL = 4'h8
  } seq_state_t;

endpackage

// ---- src/address_comparator.sv ----
// Purpose: Compares the byte span of one bus access against an address limit.
// Assumes: lo_addr <= hi_addr; both on the bus clock.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module address_comparator #(
  parameter int AW = 24
) (
  // Access span
  input wire logic [AW-1:0] lo_addr,
  input wire logic [AW-1:0] hi_addr,
  // Limit
  input wire logic [AW-1:0] limit,
  // Results
  output logic hit,
  output logic lo_below,
  output logic hi_above,
  output logic all_below,
  output logic all_above
);
  always_comb begin
    lo_below = lo_addr < limit;
    hi_above = hi_addr > limit;
    all_below = hi_addr < limit;
    all_above = lo_addr > limit;
    hit = !all_below && !all_above;
  end
endmodule // address_comparator
`default_nettype wire

// ---- src/access_qualifier.sv ----
// Purpose: Decides whether a bus access qualifies for one comparator channel.
// Assumes: Bus inputs come from logic on the same clock.
// Notes: Channels without data compare pass an all-zero mask.
`timescale 1ns/100ps
`default_nettype none
module access_qualifier #(
  parameter int DW = 32
) (
  // Channel control
  input wire logic [3:0] ctrl,
  // Bus access
  input wire logic valid,
  input wire logic read,
  input wire logic opcode,
  input wire logic vector,
  input wire logic [DW-1:0] data,
  // Data reference
  input wire logic [DW-1:0] ref_data,
  input wire logic [DW-1:0] bit_mask,
  input wire logic [DW-1:0] invert,
  // Result
  output logic ok
);
  logic kind_ok;
  logic dir_ok;
  logic data_ok;
  always_comb begin
    // Vector fetches never count as opcode fetches
    kind_ok = ctrl[debug_monitor_pkg::CTRL_OPC_BIT] ? (opcode && !vector) : !opcode;
    dir_ok = !ctrl[debug_monitor_pkg::CTRL_DIRQ_BIT] ||
             (ctrl[debug_monitor_pkg::CTRL_READ_BIT] == read);
    // Masked bits compare on equality, or on difference when inverted
    data_ok = ((((data ^ ref_data) ^ invert) & bit_mask) == '0) || opcode;
    ok = valid && ctrl[debug_monitor_pkg::CTRL_EN_BIT] && kind_ok && dir_ok && data_ok;
  end
endmodule // access_qualifier
`default_nettype wire

// ---- src/debug_monitor.sv ----
// Purpose: Bus debug monitor: comparators, range modes, state sequencer.
// Assumes: CPU bus inputs are on CLK; EXT_EVENT is an asynchronous pin.
// Notes: Registers are reached over classic Wishbone, 32-bit data.
// Operation
// - Arm bit set enters first armed state; clears itself on return to idle.
// - Disarming write leaves lower six control bits unchanged.
// - Software disarm never raises a breakpoint.
// - Writing one to force bit in a write that also sets the arm bit jumps to final state; reads zero.
// - Route bit picks background debug or software trap, gated by debug status.
// - CPU break enable requests breakpoint on entry to final state.
// - External event enable replaces channel 3 with the external event.
// - Range control is readable always, writable only while disarmed.
// - Mask bit enables data compare; invert bit selects inequality match.
// - Range match at byte granularity; opcodes use first byte address only.
// - Range modes qualify with comparator A control and data only.
// - Inside range needs both limits satisfied together.
// - Outside range matches below lower or above upper limit.
// - Vector fetches never give opcode address matches.
// - Current state's control register picks next state; transition sets flag.
`timescale 1ns/100ps
`default_nettype none
module debug_monitor #(
  parameter int AW = debug_monitor_pkg::ADDR_W,
  parameter int DW = debug_monitor_pkg::DATA_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Wishbone slave
  input wire logic [debug_monitor_pkg::IDX_W-1:0] WB_ADR,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL,
  input wire logic WB_WE,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // CPU bus monitor
  input wire logic BUS_VALID,
  input wire logic [AW-1:0] BUS_ADDR,
  input wire logic [1:0] BUS_SIZE,
  input wire logic BUS_READ,
  input wire logic BUS_OPCODE,
  input wire logic BUS_VECTOR,
  input wire logic [DW-1:0] BUS_DATA,
  // Debug environment
  input wire logic BDC_ENABLED,
  input wire logic BDM_ACTIVE,
  input wire logic EXT_EVENT,
  // Breakpoints and interrupt
  output logic BKPT_BDM,
  output logic BKPT_TRAP,
  output logic IRQ
);
  // Byte-lane merge used by the address, data, mask and invert registers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Next state for one sequencer control byte, lowest channel first
  function automatic logic [1:0] pick_target(input logic [7:0] seq, input logic [3:0] ev);
    logic [1:0] t;
    t = debug_monitor_pkg::TGT_STAY;
    for (int i = 3; i >= 0; i--) begin
      if (ev[i] && seq[2*i +: 2] != debug_monitor_pkg::TGT_STAY) begin
        t = seq[2*i +: 2];
      end
    end
    return t;
  endfunction

  // Registers
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic arm_reg, arm_next;
  logic [7:0] main_reg, main_next;
  logic [1:0] range_reg, range_next;
  logic [3:0] ctrl_reg [4];
  logic [3:0] ctrl_next [4];
  logic [AW-1:0] limit_reg [4];
  logic [AW-1:0] limit_next [4];
  logic [DW-1:0] data_a_reg, data_a_next;
  logic [DW-1:0] mask_a_reg, mask_a_next;
  logic [DW-1:0] inv_a_reg, inv_a_next;
  logic [7:0] seq1_reg, seq1_next;
  logic [7:0] seq2_reg, seq2_next;
  logic [debug_monitor_pkg::STATUS_W-1:0] status_reg, status_next;
  logic [debug_monitor_pkg::STATUS_W-1:0] irq_mask_reg, irq_mask_next;
  debug_monitor_pkg::seq_state_t state_reg, state_next;
  logic bkpt_bdm_reg, bkpt_bdm_next;
  logic bkpt_trap_reg, bkpt_trap_next;
  logic ext_meta_reg, ext_sync_reg, ext_last_reg;

  // Bus access decode
  logic wr_en;
  logic [31:0] wdata;
  logic [AW-1:0] lo_addr, hi_addr;
  logic [3:0] ch_ok, ch_hit, ch_lo_below, ch_hi_above, ch_all_below, ch_all_above;
  logic [3:0] events;
  logic range_mode;
  logic [1:0] target;
  logic force_final_state_bit_write;
  logic [debug_monitor_pkg::STATUS_W-1:0] status_set;

  assign wr_en = WB_CYC && WB_STB && WB_WE && ack_reg;
  assign wdata = WB_DAT_I;
  assign range_mode = range_reg != debug_monitor_pkg::RANGE_OFF;

  // Data accesses span all their bytes; opcodes count at the first byte only
  always_comb begin
    lo_addr = BUS_ADDR;
    hi_addr = BUS_OPCODE ? BUS_ADDR : BUS_ADDR + AW'(BUS_SIZE);
  end

  for (genvar g = 0; g < 4; g++) begin : g_chan
    // Range modes take qualification of both A and B from comparator A
    logic [3:0] qctrl;
    assign qctrl = (range_mode && g < 2) ? ctrl_reg[0] : ctrl_reg[g];
    access_qualifier #(.DW(DW)) u_qual (
      .ctrl(qctrl),
      .valid(BUS_VALID),
      .read(BUS_READ),
      .opcode(BUS_OPCODE),
      .vector(BUS_VECTOR),
      .data(BUS_DATA),
      .ref_data(data_a_reg),
      .bit_mask((g == 0 || (range_mode && g == 1)) ? mask_a_reg : '0),
      .invert(inv_a_reg),
      .ok(ch_ok[g])
    );
    address_comparator #(.AW(AW)) u_cmp (
      .lo_addr(lo_addr),
      .hi_addr(hi_addr),
      .limit(limit_reg[g]),
      .hit(ch_hit[g]),
      .lo_below(ch_lo_below[g]),
      .hi_above(ch_hi_above[g]),
      .all_below(ch_all_below[g]),
      .all_above(ch_all_above[g])
    );
  end

  // Channel events
  always_comb begin
    events = ch_ok & ch_hit;
    if (range_reg == debug_monitor_pkg::RANGE_INSIDE) begin
      // Both limits must hold at once; a lone match is not an event
      events[0] = ch_ok[0] && !ch_all_below[0] && !ch_all_above[1];
      events[1] = 1'b0;
    end else if (range_reg == debug_monitor_pkg::RANGE_OUTSIDE) begin
      // Limits at the address extremes keep vector and register reads quiet
      events[0] = ch_ok[0] && (ch_lo_below[0] || ch_hi_above[1]);
      events[1] = 1'b0;
    end
    if (main_reg[debug_monitor_pkg::MAIN_EXT_BIT]) begin
      events[3] = ext_sync_reg && !ext_last_reg;
    end
  end

  // Register file and bus answer
  always_comb begin
    ack_next = WB_CYC && WB_STB && !ack_reg;
    rdata_next = rdata_reg;
    main_next = main_reg;
    arm_next = arm_reg;
    range_next = range_reg;
    for (int i = 0; i < 4; i++) begin
      ctrl_next[i] = ctrl_reg[i];
      limit_next[i] = limit_reg[i];
    end
    data_a_next = data_a_reg;
    mask_a_next = mask_a_reg;
    inv_a_next = inv_a_reg;
    seq1_next = seq1_reg;
    seq2_next = seq2_reg;
    irq_mask_next = irq_mask_reg;
    force_final_state_bit_write = 1'b0;
    if (WB_CYC && WB_STB && !ack_reg) begin
      case (WB_ADR)
        debug_monitor_pkg::IDX_MAIN_CONTROL:
          rdata_next = {24'h000000, arm_reg, 1'b0, 1'b0, main_reg[4:0]};
        debug_monitor_pkg::IDX_RANGE_CONTROL: rdata_next = {30'h00000000, range_reg};
        debug_monitor_pkg::IDX_CMP_A_CONTROL: rdata_next = {28'h0000000, ctrl_reg[0]};
        debug_monitor_pkg::IDX_CMP_B_CONTROL: rdata_next = {28'h0000000, ctrl_reg[1]};
        debug_monitor_pkg::IDX_CMP_C_CONTROL: rdata_next = {28'h0000000, ctrl_reg[2]};
        debug_monitor_pkg::IDX_CMP_D_CONTROL: rdata_next = {28'h0000000, ctrl_reg[3]};
        debug_monitor_pkg::IDX_CMP_A_ADDR: rdata_next = 32'(limit_reg[0]);
        debug_monitor_pkg::IDX_CMP_B_ADDR: rdata_next = 32'(limit_reg[1]);
        debug_monitor_pkg::IDX_CMP_C_ADDR: rdata_next = 32'(limit_reg[2]);
        debug_monitor_pkg::IDX_CMP_D_ADDR: rdata_next = 32'(limit_reg[3]);
        debug_monitor_pkg::IDX_DATA_A: rdata_next = 32'(data_a_reg);
        debug_monitor_pkg::IDX_MASK_A: rdata_next = 32'(mask_a_reg);
        debug_monitor_pkg::IDX_INVERT_A: rdata_next = 32'(inv_a_reg);
        debug_monitor_pkg::IDX_SEQ_FIRST: rdata_next = {24'h000000, seq1_reg};
        debug_monitor_pkg::IDX_SEQ_SECOND: rdata_next = {24'h000000, seq2_reg};
        debug_monitor_pkg::IDX_STATUS: rdata_next = {26'h0000000, status_reg};
        debug_monitor_pkg::IDX_IRQ_MASK: rdata_next = {26'h0000000, irq_mask_reg};
        debug_monitor_pkg::IDX_STATE: rdata_next = {28'h0000000, state_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (wr_en && WB_SEL[0]) begin
      case (WB_ADR)
        debug_monitor_pkg::IDX_MAIN_CONTROL: begin
          arm_next = wdata[debug_monitor_pkg::MAIN_ARM_BIT];
          // Lower bits are locked while armed, even by the disarming write
          if (!arm_reg) begin
            main_next = wdata[7:0] & debug_monitor_pkg::MAIN_STORE_MASK;
          end
          force_final_state_bit_write = wdata[debug_monitor_pkg::MAIN_FORCE_FINAL_STATE_BIT_BIT] &&
                       (arm_reg || wdata[debug_monitor_pkg::MAIN_ARM_BIT]);
        end
        debug_monitor_pkg::IDX_RANGE_CONTROL: begin
          if (!arm_reg) begin
            range_next = wdata[1:0];
          end
        end
        debug_monitor_pkg::IDX_CMP_A_CONTROL: ctrl_next[0] = wdata[3:0];
        debug_monitor_pkg::IDX_CMP_B_CONTROL: ctrl_next[1] = wdata[3:0];
        debug_monitor_pkg::IDX_CMP_C_CONTROL: ctrl_next[2] = wdata[3:0];
        debug_monitor_pkg::IDX_CMP_D_CONTROL: ctrl_next[3] = wdata[3:0];
        debug_monitor_pkg::IDX_SEQ_FIRST: seq1_next = wdata[7:0];
        debug_monitor_pkg::IDX_SEQ_SECOND: seq2_next = wdata[7:0];
        debug_monitor_pkg::IDX_IRQ_MASK: irq_mask_next = wdata[debug_monitor_pkg::STATUS_W-1:0];
        default: ;
      endcase
    end
    if (wr_en) begin
      case (WB_ADR)
        debug_monitor_pkg::IDX_CMP_A_ADDR: limit_next[0] = AW'(merge(32'(limit_reg[0]), wdata, WB_SEL));
        debug_monitor_pkg::IDX_CMP_B_ADDR: limit_next[1] = AW'(merge(32'(limit_reg[1]), wdata, WB_SEL));
        debug_monitor_pkg::IDX_CMP_C_ADDR: limit_next[2] = AW'(merge(32'(limit_reg[2]), wdata, WB_SEL));
        debug_monitor_pkg::IDX_CMP_D_ADDR: limit_next[3] = AW'(merge(32'(limit_reg[3]), wdata, WB_SEL));
        debug_monitor_pkg::IDX_DATA_A: data_a_next = DW'(merge(32'(data_a_reg), wdata, WB_SEL));
        debug_monitor_pkg::IDX_MASK_A: mask_a_next = DW'(merge(32'(mask_a_reg), wdata, WB_SEL));
        debug_monitor_pkg::IDX_INVERT_A: inv_a_next = DW'(merge(32'(inv_a_reg), wdata, WB_SEL));
        default: ;
      endcase
    end
    // Session end clears the arm bit on the return to idle
    if (state_reg == debug_monitor_pkg::ST_FINAL) begin
      arm_next = 1'b0;
    end
  end

  // State sequencer and breakpoints
  always_comb begin
    state_next = state_reg;
    status_set = '0;
    bkpt_bdm_next = 1'b0;
    bkpt_trap_next = 1'b0;
    target = debug_monitor_pkg::TGT_STAY;
    case (state_reg)
      debug_monitor_pkg::ST_IDLE: begin
        if (arm_next) begin
          state_next = debug_monitor_pkg::ST_FIRST;
        end
      end
      debug_monitor_pkg::ST_FIRST: target = pick_target(seq1_reg, events);
      debug_monitor_pkg::ST_SECOND: target = pick_target(seq2_reg, events);
      debug_monitor_pkg::ST_FINAL: begin
        state_next = debug_monitor_pkg::ST_IDLE;
        status_set[debug_monitor_pkg::ST_DONE_BIT] = 1'b1;
        if (main_reg[debug_monitor_pkg::MAIN_CPUBRK_BIT]) begin
          if (main_reg[debug_monitor_pkg::MAIN_ROUTE_BIT]) begin
            bkpt_bdm_next = BDC_ENABLED;
          end else begin
            bkpt_trap_next = !BDM_ACTIVE;
          end
        end
      end
      default: state_next = debug_monitor_pkg::ST_IDLE;
    endcase
    if (target != debug_monitor_pkg::TGT_STAY) begin
      // The flag of the winning channel records the transition
      for (int i = 3; i >= 0; i--) begin
        if (events[i] && pick_target(state_reg == debug_monitor_pkg::ST_FIRST ? seq1_reg : seq2_reg,
                                     4'(1 << i)) == target) begin
          status_set = '0;
          status_set[i] = 1'b1;
        end
      end
      case (target)
        debug_monitor_pkg::TGT_FIRST: state_next = debug_monitor_pkg::ST_FIRST;
        debug_monitor_pkg::TGT_SECOND: state_next = debug_monitor_pkg::ST_SECOND;
        default: state_next = debug_monitor_pkg::ST_FINAL;
      endcase
    end
    if (force_final_state_bit_write) begin
      state_next = debug_monitor_pkg::ST_FINAL;
      status_set[debug_monitor_pkg::ST_FORCE_FINAL_STATE_BIT_BIT] = 1'b1;
    end
    // A software disarm drops the session without any breakpoint
    if (arm_reg && !arm_next && state_reg != debug_monitor_pkg::ST_FINAL) begin
      state_next = debug_monitor_pkg::ST_IDLE;
      status_set = '0;
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_comb begin
    status_next = status_reg;
    if (wr_en && WB_SEL[0] && WB_ADR == debug_monitor_pkg::IDX_STATUS) begin
      status_next = status_reg & ~wdata[debug_monitor_pkg::STATUS_W-1:0];
    end
    status_next = status_next | status_set;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      arm_reg <= 1'b0;
      main_reg <= debug_monitor_pkg::MAIN_CONTROL_RST;
      range_reg <= debug_monitor_pkg::RANGE_OFF;
      for (int i = 0; i < 4; i++) begin
        ctrl_reg[i] <= debug_monitor_pkg::CTRL_RST;
        limit_reg[i] <= '0;
      end
      data_a_reg <= '0;
      mask_a_reg <= '0;
      inv_a_reg <= '0;
      seq1_reg <= 8'h00;
      seq2_reg <= 8'h00;
      status_reg <= '0;
      irq_mask_reg <= '0;
      state_reg <= debug_monitor_pkg::ST_IDLE;
      bkpt_bdm_reg <= 1'b0;
      bkpt_trap_reg <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_last_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      arm_reg <= arm_next;
      main_reg <= main_next;
      range_reg <= range_next;
      for (int i = 0; i < 4; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
        limit_reg[i] <= limit_next[i];
      end
      data_a_reg <= data_a_next;
      mask_a_reg <= mask_a_next;
      inv_a_reg <= inv_a_next;
      seq1_reg <= seq1_next;
      seq2_reg <= seq2_next;
      status_reg <= status_next;
      irq_mask_reg <= irq_mask_next;
      state_reg <= state_next;
      bkpt_bdm_reg <= bkpt_bdm_next;
      bkpt_trap_reg <= bkpt_trap_next;
      ext_meta_reg <= EXT_EVENT;
      ext_sync_reg <= ext_meta_reg;
      ext_last_reg <= ext_sync_reg;
    end
  end

  assign WB_ACK = ack_reg;
  assign WB_DAT_O = rdata_reg;
  assign BKPT_BDM = bkpt_bdm_reg;
  assign BKPT_TRAP = bkpt_trap_reg;
  assign IRQ = |(status_reg & irq_mask_reg);

endmodule // debug_monitor
`default_nettype wire

// ---- tb/debug_monitor_asserts.sv ----
// Purpose: Port checks for the debug monitor.
// Assumes: One clock, RST_B synchronous active low.
// Notes: Three quiet cycles after a disarm cover the registered break path.
`timescale 1ns/100ps
`default_nettype none
module debug_monitor_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Register bus
  input wire logic [debug_monitor_pkg::IDX_W-1:0] WB_ADR,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_WE,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK,
  // Environment and breakpoints
  input wire logic BDC_ENABLED,
  input wire logic BDM_ACTIVE,
  input wire logic BKPT_BDM,
  input wire logic BKPT_TRAP,
  input wire logic IRQ
);
  logic mc_ack;
  logic brk;
  assign mc_ack = WB_ACK && (WB_ADR == debug_monitor_pkg::IDX_MAIN_CONTROL);
  assign brk = BKPT_BDM || BKPT_TRAP;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_rst; $rose(RST_B) |-> !brk && !IRQ && !WB_ACK; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_bdm; BKPT_BDM |-> $past(BDC_ENABLED); endproperty
  a_bdm: assert property (p_bdm) else $error("debug break, no controller");
  property p_trap; BKPT_TRAP |-> !$past(BDM_ACTIVE); endproperty
  a_trap: assert property (p_trap) else $error("trap while debug active");
  property p_one; !(BKPT_BDM && BKPT_TRAP); endproperty
  a_one: assert property (p_one) else $error("both breakpoints");
  property p_disarm; mc_ack && WB_WE && !WB_DAT_I[7] |=> !brk [*3]; endproperty
  a_disarm: assert property (p_disarm) else $error("break on disarm");
  property p_force; mc_ack && !WB_WE |-> !WB_DAT_O[6]; endproperty
  a_force: assert property (p_force) else $error("force bit read as one");
  property p_pulse; brk |=> !brk; endproperty
  a_pulse: assert property (p_pulse) else $error("breakpoint held");
  property p_ans; WB_CYC && WB_STB && !WB_ACK |=> WB_ACK; endproperty
  a_ans: assert property (p_ans) else $error("request unanswered");
endmodule // debug_monitor_asserts
`default_nettype wire

// ---- tb/cpu_bus_model.sv ----
// Purpose: CPU bus side feeding single accesses to the monitor.
// Assumes: One access lasts one cycle.
// Notes: Idle lines except BUS_READ carry the inverse of the last access, not a held copy.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input wire logic CLK,
  // Access
  output logic BUS_VALID,
  output logic [23:0] BUS_ADDR,
  output logic [1:0] BUS_SIZE,
  output logic BUS_READ,
  output logic BUS_OPCODE,
  output logic BUS_VECTOR,
  output logic [31:0] BUS_DATA
);
  initial {BUS_VALID, BUS_ADDR, BUS_SIZE, BUS_READ, BUS_OPCODE, BUS_VECTOR, BUS_DATA} = '0;
  task automatic access(input logic [23:0] a, input logic [1:0] s, input logic op,
    input logic vec, input logic [31:0] d);
    @(posedge CLK);
    {BUS_VALID, BUS_ADDR, BUS_SIZE, BUS_READ, BUS_OPCODE, BUS_VECTOR, BUS_DATA} <=
      {1'b1, a, s, 1'b1, op, vec, d};
    @(posedge CLK);
    {BUS_VALID, BUS_ADDR, BUS_SIZE, BUS_OPCODE, BUS_VECTOR, BUS_DATA} <=
      {1'b0, ~a, ~s, ~op, ~vec, ~d};
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// ---- tb/debug_monitor_test.sv ----
// Purpose: Self-checking bench for the debug monitor.
// Assumes: Classic Wishbone master, 10 MHz clock, reset low for 8 cycles.
// Notes: Expected values come from rule tables, never from the design.
`timescale 1ns/100ps
`default_nettype none
module debug_monitor_test;
  localparam logic [9:0] MC = debug_monitor_pkg::IDX_MAIN_CONTROL;
  localparam logic [9:0] RC = debug_monitor_pkg::IDX_RANGE_CONTROL;
  localparam logic [9:0] ST = debug_monitor_pkg::IDX_STATE;
  localparam logic [9:0] SR = debug_monitor_pkg::IDX_STATUS;
  logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, irq;
  logic bdc_en = 1'b0, bdm_act = 1'b0, ext = 1'b0, bkb, bkt, bv, brd, bop, bvec;
  logic [9:0] adr = '0;
  logic [31:0] dw = '0, dr, rd, bd, seed = 32'h22606600;
  logic [23:0] ba, a;
  logic [1:0] bs;
  logic [5:0] f;
  logic [19:0] e;
  int n_fail = 0, n_checks = 0, ncyc = 0, nb = 0, nt = 0, b0, t0, em;
  // Route, cpu break, controller, debug active, expected debug break, expected trap
  logic [5:0] ftab [5] = '{6'h3A, 6'h11, 6'h30, 6'h14, 6'h00};
  // Expect, opcode, vector, size, range mode, data differs, control A, signed offset from A
  logic [19:0] ctab [11] = '{20'h00108, 20'h80100, 20'h60300, 20'hC0300, 20'h82104,
    20'h02120, 20'h04104, 20'h84120, 20'h9A1FE, 20'h5A3FE, 20'h01100};
  debug_monitor uut (.CLK(clk), .RST_B(rst_b), .WB_ADR(adr), .WB_DAT_I(dw), .WB_SEL(4'hF),
    .WB_WE(we), .WB_CYC(cyc), .WB_STB(stb), .WB_DAT_O(dr), .WB_ACK(ack), .BUS_VALID(bv),
    .BUS_ADDR(ba), .BUS_SIZE(bs), .BUS_READ(brd), .BUS_OPCODE(bop), .BUS_VECTOR(bvec),
    .BUS_DATA(bd), .BDC_ENABLED(bdc_en), .BDM_ACTIVE(bdm_act), .EXT_EVENT(ext),
    .BKPT_BDM(bkb), .BKPT_TRAP(bkt), .IRQ(irq));
  cpu_bus_model bus (.CLK(clk), .BUS_VALID(bv), .BUS_ADDR(ba), .BUS_SIZE(bs), .BUS_READ(brd),
    .BUS_OPCODE(bop), .BUS_VECTOR(bvec), .BUS_DATA(bd));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    nb <= nb + int'(bkb);
    nt <= nt + int'(bkt);
    if (ncyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] ad, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dw} <= {1'b1, 1'b1, w, ad, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dr;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rchk(input logic [9:0] ad, input logic [31:0] x);
    wb(1'b0, ad, 0);
    check(rd, x);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rchk(MC, 0);
    rchk(RC, 0);
    rchk(ST, 1);
    rchk(SR, 0);
    rchk(10'h3FF, 0);
    $display("reset test done");
    wb(1, RC, 1);
    wb(1, MC, 32'h80);
    rchk(ST, 2);
    wb(1, RC, 2);
    rchk(RC, 1);
    wb(1, MC, 0);
    rchk(ST, 1);
    wb(1, MC, 32'h18);
    wb(1, MC, 32'h98);
    b0 = nb + nt;
    wb(1, MC, 32'h02);
    rchk(MC, 32'h18);
    check(nb + nt - b0, 0);
    $display("arm test done");
    for (int i = 0; i < 5; i++) begin
      f = ftab[i];
      bdc_en <= f[3];
      bdm_act <= f[2];
      em = f[5] * 16 + f[4] * 8;
      wb(1, MC, em);
      wb(1, debug_monitor_pkg::IDX_IRQ_MASK, i % 2 ? 32'h20 : 0);
      b0 = nb;
      t0 = nt;
      wb(1, MC, em + 32'hC0);
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(nb - b0, f[1]);
      check(nt - t0, f[0]);
      check(irq, i % 2); // Done flag unmasked on odd passes only
      rchk(MC, em);
      rchk(SR, 32'h30);
      wb(1, SR, 32'h3F);
      @(negedge clk);
      check(irq, 0);
    end
    $display("force test done");
    seed = xs(seed);
    a = (seed[23:0] & 24'h7FFFF0) + 24'h100;
    wb(1, debug_monitor_pkg::IDX_CMP_A_ADDR, a); // Limits kept off the extremes
    wb(1, debug_monitor_pkg::IDX_CMP_B_ADDR, a + 24'h10);
    wb(1, debug_monitor_pkg::IDX_SEQ_FIRST, 3);
    wb(1, debug_monitor_pkg::IDX_DATA_A, 32'h55);
    wb(1, debug_monitor_pkg::IDX_MASK_A, 32'hFF);
    // Low nibble matches on difference, so only 8'h5A in the low byte matches
    wb(1, debug_monitor_pkg::IDX_INVERT_A, 32'h0F);
    for (int i = 0; i < 11; i++) begin
      e = ctab[i];
      wb(1, RC, e[14:13]);
      wb(1, debug_monitor_pkg::IDX_CMP_A_CONTROL, e[11:8]);
      wb(1, MC, 32'h88);
      t0 = nt;
      seed = xs(seed);
      bus.access(a + {{16{e[7]}}, e[7:0]}, e[16:15], e[18], e[17],
                 {seed[31:8], e[12] ? 8'h55 : 8'h5A});
      repeat (6) @(posedge clk);
      check(nt - t0, e[19]);
      rchk(SR, e[19] ? 32'h21 : 32'h0);
      wb(1, MC, 0);
      wb(1, SR, 32'h3F);
    end
    $display("comparator test done");
    wb(1, debug_monitor_pkg::IDX_SEQ_FIRST, 32'hC0);
    for (int i = 0; i < 2; i++) begin
      wb(1, MC, 32'h88 + 2 * i);
      t0 = nt;
      ext <= 1'b1;
      repeat (8) @(posedge clk);
      ext <= 1'b0;
      check(nt - t0, i);
      rchk(SR, i ? 32'h28 : 32'h0);
      wb(1, MC, 0);
    end
    $display("event test done");
    summarize();
  end
endmodule // debug_monitor_test
bind debug_monitor debug_monitor_asserts chk (.CLK, .RST_B, .WB_ADR, .WB_DAT_I, .WB_WE,
  .WB_CYC, .WB_STB, .WB_DAT_O, .WB_ACK, .BDC_ENABLED, .BDM_ACTIVE, .BKPT_BDM, .BKPT_TRAP,
  .IRQ);
`default_nettype wire
